// ---- hw/tmr8_top.sv ----
// Two-channel 8-bit timer with APB registers and one interrupt line.
`timescale 1ns/1ns
// Contract
// RQ1: Select 000 stops; 001/010/011 count at core clock /8, /64, /8192.
// RQ2: External rising-edge select counts each rising edge of the clock pin.
// RQ3: External falling-edge select counts each falling edge of the clock pin.
// RQ4: Dual-edge select counts both edges of the external clock pin.
// RQ5: Channel 0 with select 100 counts channel 1 overflows.
// RQ6: Channel 1 with select 100 counts channel 0 compare match A.
// RQ7: Match B requests interrupt only while its enable bit is one.
// RQ8: Match B flag sets when counter equals time constant B.
// RQ9: Flags 7 to 5 clear only by writing zero; ones are ignored.
// RQ10: Clear field: never, match A, match B, or external reset rising edge.
// RQ11: Overflow and match A interrupts need enables; controls reset to zero.
module tmr8_top #(
  parameter int DIV_SLOW = tmr8_pkg::DIV_SLOW
) (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [tmr8_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [1:0] EXT_CLK_I,
  input wire logic [1:0] EXT_RST_I,
  output logic IRQ_O
);
  import tmr8_pkg::*;

  logic [1:0][7:0] ctrl_reg;
  logic [1:0][7:0] ctrl_next;
  logic [1:0][EV_W-1:0] flag_reg;
  logic [1:0][EV_W-1:0] flag_next;
  logic [1:0][7:0] tca_reg;
  logic [1:0][7:0] tca_next;
  logic [1:0][7:0] tcb_reg;
  logic [1:0][7:0] tcb_next;
  logic [5:0] irq_st_reg;
  logic [5:0] irq_st_next;
  logic [5:0] irq_mask_reg;
  logic [5:0] irq_mask_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [15:0] idx;
  logic setup;
  logic wr_acc;
  logic mapped;
  logic tick8;
  logic tick64;
  logic tick8192;
  wire [1:0] step;
  wire [1:0] ovf;
  wire [1:0] match_a;
  wire [1:0] match_b;
  wire [1:0] eclk_rise;
  wire [1:0] eclk_fall;
  wire [1:0] erst_rise;
  wire [1:0] cnt_wr;
  wire [1:0][7:0] cnt;
  wire [1:0][EV_W-1:0] events;

  // APB decode. The slave never inserts wait states.
  assign idx = PADDR_I[ADDR_W-1:BYTE_SHIFT];
  assign setup = PSEL_I && !PENABLE_I;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign mapped = (idx >= IDX_CTRL0) && (idx <= IDX_IRQ_MASK);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
  assign PRDATA_O = prdata_reg;

  // The dividers run free from reset and are shared by both channels, so
  // the first tick after a select change may come early by up to one
  // divided period; this costs less than one divider per channel.
  tmr8_prescale #(.DIV(DIV_FAST)) u_div_fast (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .tick_o(tick8)
  );
  tmr8_prescale #(.DIV(DIV_MID)) u_div_mid (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .tick_o(tick64)
  );
  tmr8_prescale #(.DIV(DIV_SLOW)) u_div_slow (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .tick_o(tick8192)
  );

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [2:0] eclk_reg;
    logic [2:0] eclk_next;
    logic [2:0] erst_reg;
    logic [2:0] erst_next;
    logic step_c;
    logic [2:0] cks;

    // Pins pass two flops; edges are taken between stages two and three.
    always_comb begin
      eclk_next = {eclk_reg[1:0], EXT_CLK_I[c]};
      erst_next = {erst_reg[1:0], EXT_RST_I[c]};
    end

    always_ff @(posedge CORE_CLK_I) begin
      if (!NRST_I) begin
        eclk_reg <= '0;
        erst_reg <= '0;
      end else begin
        eclk_reg <= eclk_next;
        erst_reg <= erst_next;
      end
    end

    assign eclk_rise[c] = eclk_reg[1] && !eclk_reg[2];
    assign eclk_fall[c] = !eclk_reg[1] && eclk_reg[2];
    assign erst_rise[c] = erst_reg[1] && !erst_reg[2];
    assign cks = ctrl_reg[c][CTRL_CKS_MSB:CTRL_CKS_LSB];

    always_comb begin
      unique case (cks)
        CKS_OFF: step_c = 1'b0; // RQ1
        CKS_DIV8: step_c = tick8; // RQ1
        CKS_DIV64: step_c = tick64; // RQ1
        CKS_DIV8192: step_c = tick8192; // RQ1
        // Cascade sources depend only on the other channel's registers, so no loop forms.
        CKS_CASCADE: step_c = (c == 0) ? ovf[1] : match_a[0]; // RQ5 RQ6
        CKS_EXT_RISE: step_c = eclk_rise[c]; // RQ2
        CKS_EXT_FALL: step_c = eclk_fall[c]; // RQ3
        CKS_EXT_BOTH: step_c = eclk_rise[c] || eclk_fall[c]; // RQ4
      endcase
    end

    assign step[c] = step_c;
    assign cnt_wr[c] = wr_acc && (idx == ((c == 0) ? IDX_CNT0 : IDX_CNT1));
    assign events[c] = {match_b[c], match_a[c], ovf[c]};

    tmr8_channel #(.W(CNT_W)) u_ch (
      .clk_i(CORE_CLK_I),
      .nrst_i(NRST_I),
      .step_i(step[c]),
      .clear_sel_i(ctrl_reg[c][CTRL_CCLR_MSB:CTRL_CCLR_LSB]),
      .ext_rst_rise_i(erst_rise[c]),
      .tca_i(tca_reg[c]),
      .tcb_i(tcb_reg[c]),
      .wr_i(cnt_wr[c]),
      .wdata_i(PWDATA_I[CNT_W-1:0]),
      .cnt_o(cnt[c]),
      .match_a_o(match_a[c]),
      .match_b_o(match_b[c]),
      .ovf_o(ovf[c])
    );
  end

  // Register writes; a flag event in the clearing cycle still sets it.
  always_comb begin
    ctrl_next = ctrl_reg;
    tca_next = tca_reg;
    tcb_next = tcb_reg;
    irq_mask_next = irq_mask_reg;
    irq_st_next = irq_st_reg | {events[1], events[0]};
    for (int c = 0; c < 2; c++) begin
      flag_next[c] = flag_reg[c] | events[c]; // RQ8
    end
    if (wr_acc) begin
      case (idx)
        IDX_CTRL0: ctrl_next[0] = PWDATA_I[7:0];
        IDX_CTRL1: ctrl_next[1] = PWDATA_I[7:0];
        IDX_CSR0: flag_next[0] = (flag_reg[0] // RQ9
          & PWDATA_I[FLAG_MSB:FLAG_LSB]) | events[0];
        IDX_CSR1: flag_next[1] = (flag_reg[1] // RQ9
          & PWDATA_I[FLAG_MSB:FLAG_LSB]) | events[1];
        IDX_TCA0: tca_next[0] = PWDATA_I[7:0];
        IDX_TCA1: tca_next[1] = PWDATA_I[7:0];
        IDX_TCB0: tcb_next[0] = PWDATA_I[7:0];
        IDX_TCB1: tcb_next[1] = PWDATA_I[7:0];
        IDX_IRQ_ST: irq_st_next = (irq_st_reg & ~PWDATA_I[5:0])
          | {events[1], events[0]};
        IDX_IRQ_MASK: irq_mask_next = PWDATA_I[5:0];
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup phase and held in the access phase.
  always_comb begin
    prdata_next = prdata_reg;
    if (setup && !PWRITE_I) begin
      prdata_next = '0;
      case (idx)
        IDX_CTRL0: prdata_next[7:0] = ctrl_reg[0];
        IDX_CTRL1: prdata_next[7:0] = ctrl_reg[1];
        IDX_CSR0: prdata_next[FLAG_MSB:FLAG_LSB] = flag_reg[0];
        IDX_CSR1: prdata_next[FLAG_MSB:FLAG_LSB] = flag_reg[1];
        IDX_TCA0: prdata_next[7:0] = tca_reg[0];
        IDX_TCA1: prdata_next[7:0] = tca_reg[1];
        IDX_TCB0: prdata_next[7:0] = tcb_reg[0];
        IDX_TCB1: prdata_next[7:0] = tcb_reg[1];
        IDX_CNT0: prdata_next[7:0] = cnt[0];
        IDX_CNT1: prdata_next[7:0] = cnt[1];
        IDX_IRQ_ST: prdata_next[5:0] = irq_st_reg;
        IDX_IRQ_MASK: prdata_next[5:0] = irq_mask_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!NRST_I) begin
      ctrl_reg <= {2{CTRL_RST}}; // RQ11
      flag_reg <= '0;
      tca_reg <= {2{TCONST_RST}};
      tcb_reg <= {2{TCONST_RST}};
      irq_st_reg <= '0;
      irq_mask_reg <= '0;
      prdata_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      flag_reg <= flag_next;
      tca_reg <= tca_next;
      tcb_reg <= tcb_next;
      irq_st_reg <= irq_st_next;
      irq_mask_reg <= irq_mask_next;
      prdata_reg <= prdata_next;
    end
  end

  // Both the per-source enable and the mask must be set to reach the pin.
  assign IRQ_O = |(irq_st_reg & irq_mask_reg // RQ7 RQ11
    & {ctrl_reg[1][CTRL_EN_MSB:CTRL_EN_LSB],
       ctrl_reg[0][CTRL_EN_MSB:CTRL_EN_LSB]});

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);

  chk_flag_b_set: assert property ( // RQ8
    match_b[0] |=> flag_reg[0][EV_MB] && irq_st_reg[EV_MB])
    else $error("Match B event did not set its flags.");
  chk_flag_wr_one: assert property ( // RQ9
    (wr_acc && idx == IDX_CSR0 && PWDATA_I[FLAG_MSB] && flag_reg[0][EV_MB])
    |=> flag_reg[0][EV_MB])
    else $error("Writing one changed a status flag.");
  chk_flag_wr_zero: assert property ( // RQ9
    (wr_acc && idx == IDX_CSR0 && !PWDATA_I[FLAG_MSB] && !match_b[0])
    |=> !flag_reg[0][EV_MB])
    else $error("Writing zero did not clear a status flag.");
  chk_irq_b_block: assert property ( // RQ7
    (irq_mask_reg == 6'h04 && !ctrl_reg[0][CTRL_EN_MSB]) |-> !IRQ_O)
    else $error("Match B request passed with its enable off.");
  chk_irq_b_pass: assert property ( // RQ7
    (irq_mask_reg[EV_MB] && ctrl_reg[0][CTRL_EN_MSB] && match_b[0]
     && !wr_acc) |=> IRQ_O)
    else $error("Enabled match B event raised no interrupt.");
  chk_irq_ovf_block: assert property ( // RQ11
    (irq_mask_reg == 6'h08 && !ctrl_reg[1][CTRL_EN_LSB]) |-> !IRQ_O)
    else $error("Overflow request passed with its enable off.");
  chk_ext_rise_cnt: assert property ( // RQ2
    ($rose(EXT_CLK_I[0]) && ctrl_reg[0][2:0] == CKS_EXT_RISE)
    |-> ##2 (step[0] || ctrl_reg[0][2:0] != CKS_EXT_RISE))
    else $error("Rising external clock edge was not counted.");
  chk_ext_fall_cnt: assert property ( // RQ3
    ($fell(EXT_CLK_I[0]) && ctrl_reg[0][2:0] == CKS_EXT_FALL)
    |-> ##2 (step[0] || ctrl_reg[0][2:0] != CKS_EXT_FALL))
    else $error("Falling external clock edge was not counted.");
  chk_ext_both_cnt: assert property ( // RQ4
    (ctrl_reg[0][2:0] == CKS_EXT_BOTH && (eclk_rise[0] || eclk_fall[0]))
    |-> step[0])
    else $error("Dual-edge mode missed an edge.");
  chk_cascade_ch0: assert property ( // RQ5
    (ctrl_reg[0][2:0] == CKS_CASCADE) |-> step[0] == ovf[1])
    else $error("Channel 0 not stepped by channel 1 overflow.");
  chk_cascade_ch1: assert property ( // RQ6
    (ctrl_reg[1][2:0] == CKS_CASCADE) |-> step[1] == match_a[0])
    else $error("Channel 1 not stepped by channel 0 match.");
  chk_clock_off: assert property ( // RQ1
    (ctrl_reg[0][2:0] == CKS_OFF) |-> !step[0])
    else $error("Counter stepped with its clock disabled.");

  // Software polls the registers for events it has missed on the line,
  // so flag, status, control, counter and read data paths are checked as well as the interrupt.
  chk_flag_a_set: assert property (
    match_a[0] |=> flag_reg[0][EV_MA] && irq_st_reg[EV_MA])
    else $error("Match A event did not set its flags.");
  chk_flag_ovf_set: assert property ( // RQ11
    ovf[1] |=> flag_reg[1][EV_OVF] && irq_st_reg[EV_W + EV_OVF])
    else $error("Overflow event did not set its flags.");
  chk_erst_sync: assert property ( // RQ10
    $rose(EXT_RST_I[1]) |-> ##2 erst_rise[1])
    else $error("External reset edge was lost in the synchroniser.");
  chk_ctrl_write: assert property ( // RQ11
    (wr_acc && idx == IDX_CTRL1) |=> ctrl_reg[1] == $past(PWDATA_I[7:0]))
    else $error("Control register write did not land.");
  chk_cnt_write: assert property (
    cnt_wr[0] |=> cnt[0] == $past(PWDATA_I[7:0]))
    else $error("Counter write did not land.");
  chk_read_capture: assert property (
    (setup && !PWRITE_I && idx == IDX_TCA0)
    |=> PRDATA_O == {24'h0, $past(tca_reg[0])})
    else $error("Read data did not capture the addressed register.");
  chk_irq_st_w1c: assert property (
    (wr_acc && idx == IDX_IRQ_ST && PWDATA_I[EV_MB] && !match_b[0])
    |=> !irq_st_reg[EV_MB])
    else $error("Writing one did not clear interrupt status.");
  chk_slverr_unmapped: assert property (
    (PSEL_I && PENABLE_I && idx > IDX_IRQ_MASK) |-> PSLVERR_O)
    else $error("Unmapped access raised no slave error.");
endmodule // tmr8_top

// ---- shared/tmr8_pkg.sv ----
// Constants shared by the two-channel 8-bit timer.
package tmr8_pkg;
  localparam int ADDR_W = 18;
  localparam int BYTE_SHIFT = 2;
  localparam int CNT_W = 8;
  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_CTRL0 = 16'hffb0;
  localparam logic [15:0] IDX_CTRL1 = 16'hffb1;
  localparam logic [15:0] IDX_CSR0 = 16'hffb2;
  localparam logic [15:0] IDX_CSR1 = 16'hffb3;
  localparam logic [15:0] IDX_TCA0 = 16'hffb4;
  localparam logic [15:0] IDX_TCA1 = 16'hffb5;
  localparam logic [15:0] IDX_TCB0 = 16'hffb6;
  localparam logic [15:0] IDX_TCB1 = 16'hffb7;
  localparam logic [15:0] IDX_CNT0 = 16'hffb8;
  localparam logic [15:0] IDX_CNT1 = 16'hffb9;
  localparam logic [15:0] IDX_IRQ_ST = 16'hffba;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hffbb;
  // Control register fields.
  localparam int CTRL_CKS_LSB = 0;
  localparam int CTRL_CKS_MSB = 2;
  localparam int CTRL_CCLR_LSB = 3;
  localparam int CTRL_CCLR_MSB = 4;
  localparam int CTRL_EN_LSB = 5;
  localparam int CTRL_EN_MSB = 7;
  // Flag field of the control/status register.
  localparam int FLAG_LSB = 5;
  localparam int FLAG_MSB = 7;
  // Event order inside a flag or enable field.
  localparam int EV_OVF = 0;
  localparam int EV_MA = 1;
  localparam int EV_MB = 2;
  localparam int EV_W = 3;
  // Clock select codes.
  localparam logic [2:0] CKS_OFF = 3'h0;
  localparam logic [2:0] CKS_DIV8 = 3'h1;
  localparam logic [2:0] CKS_DIV64 = 3'h2;
  localparam logic [2:0] CKS_DIV8192 = 3'h3;
  localparam logic [2:0] CKS_CASCADE = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
  // Counter clear codes.
  localparam logic [1:0] CCLR_NONE = 2'h0;
  localparam logic [1:0] CCLR_MATCH_A = 2'h1;
  localparam logic [1:0] CCLR_MATCH_B = 2'h2;
  localparam logic [1:0] CCLR_EXT = 2'h3;
  // Prescaler ratios of the core clock.
  localparam int DIV_FAST = 8;
  localparam int DIV_MID = 64;
  localparam int DIV_SLOW = 8192;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TCONST_RST = 8'hff;
  localparam logic [7:0] CNT_RST = 8'h00;
endpackage

// ---- hw/tmr8_prescale.sv ----
// Divider that turns the core clock into a one-cycle count enable.
`timescale 1ns/1ns
module tmr8_prescale #(
  parameter int DIV = tmr8_pkg::DIV_FAST
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  output logic tick_o
);
  import tmr8_pkg::*;

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  always_comb begin
    cnt_next = (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // The pulse marks the falling edge of the divided clock.
  assign tick_o = (cnt_reg == LAST);

  chk_tick_single: assert property ( // RQ1
    @(posedge clk_i) disable iff (!nrst_i)
    tick_o |=> !tick_o)
    else $error("Prescaler tick lasted more than one cycle.");
endmodule // tmr8_prescale

// ---- hw/tmr8_channel.sv ----
// One 8-bit up-counter with two compare matches and overflow.
`timescale 1ns/1ns
module tmr8_channel #(
  parameter int W = tmr8_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic step_i,
  input wire logic [1:0] clear_sel_i,
  input wire logic ext_rst_rise_i,
  input wire logic [W-1:0] tca_i,
  input wire logic [W-1:0] tcb_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] cnt_o,
  output logic match_a_o,
  output logic match_b_o,
  output logic ovf_o
);
  import tmr8_pkg::*;

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic eq_a_reg;
  logic eq_b_reg;
  logic ovf_reg;
  logic ovf_next;
  logic clear;
  logic eq_a;
  logic eq_b;

  // A match is reported once when equality begins, not every cycle.
  assign eq_a = (cnt_reg == tca_i);
  assign eq_b = (cnt_reg == tcb_i);
  assign match_a_o = eq_a && !eq_a_reg;
  assign match_b_o = eq_b && !eq_b_reg; // RQ8

  always_comb begin
    unique case (clear_sel_i) // RQ10
      CCLR_NONE: clear = 1'b0;
      CCLR_MATCH_A: clear = match_a_o;
      CCLR_MATCH_B: clear = match_b_o;
      CCLR_EXT: clear = ext_rst_rise_i;
    endcase
    cnt_next = cnt_reg;
    ovf_next = 1'b0;
    // A software write wins over a clear, which wins over a count.
    if (wr_i) begin
      cnt_next = wdata_i;
    end else if (clear) begin
      cnt_next = '0;
    end else if (step_i) begin
      cnt_next = cnt_reg + 1'b1;
      ovf_next = &cnt_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg <= CNT_RST;
      eq_a_reg <= 1'b0;
      eq_b_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      eq_a_reg <= eq_a;
      eq_b_reg <= eq_b;
      ovf_reg <= ovf_next;
    end
  end

  assign cnt_o = cnt_reg;
  assign ovf_o = ovf_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_clear_match_a: assert property ( // RQ10
    (clear_sel_i == CCLR_MATCH_A && match_a_o && !wr_i) |=> cnt_reg == '0)
    else $error("Counter not cleared by compare match A.");
  chk_clear_ext_rst: assert property ( // RQ10
    (clear_sel_i == CCLR_EXT && ext_rst_rise_i && !wr_i) |=> cnt_reg == '0)
    else $error("Counter not cleared by external reset edge.");
  chk_hold_no_step: assert property ( // RQ10
    (clear_sel_i == CCLR_NONE && !wr_i && !step_i)
    |=> cnt_reg == $past(cnt_reg))
    else $error("Counter moved without a count or write.");
  chk_step_count: assert property ( // RQ1
    (step_i && !wr_i && !clear) |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("Counter did not advance by one on a count.");
  chk_ovf_wrap: assert property (
    ovf_reg |-> cnt_reg == '0 ##1 !ovf_reg)
    else $error("Overflow pulse without wrap to zero.");
endmodule // tmr8_channel

// ---- tb/tmr8_pins.sv ----
// Model of the external count clock and counter reset pins.
`timescale 1ns/1ns
module tmr8_pins (
  input wire logic clk_i,
  output logic [1:0] ext_clk_o,
  output logic [1:0] ext_rst_o
);
  initial begin
    ext_clk_o <= 2'h0;
    ext_rst_o <= 2'h0;
  end
  // High is held three core cycles and low four or more, since the pins pass two sync
  // flops and a shorter pulse may be missed.
  task pulse(input bit rst, input int ch, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (rst)
        ext_rst_o[ch] <= 1'b1;
      else
        ext_clk_o[ch] <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_rst_o[ch] <= 1'b0;
      ext_clk_o[ch] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask
endmodule // tmr8_pins

// ---- tb/test_dual_8bit_timer_control.sv ----
// Self-checking bench for the two-channel 8-bit timer.
`timescale 1ns/1ns
module test_dual_8bit_timer_control;
  import tmr8_pkg::*;
  localparam logic [15:0] RIX [10] = '{IDX_CTRL0, IDX_CTRL1, IDX_CSR0,
    IDX_CSR1, IDX_TCA0, IDX_TCA1, IDX_TCB0, IDX_CNT0, IDX_IRQ_ST,
    IDX_IRQ_MASK};
  localparam int EXP [4] = '{0, 20, 2, 10};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] ext_clk;
  logic [1:0] ext_rst;
  logic irq;
  logic [31:0] rv;
  logic er;
  int miscompares = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  tmr8_top #(.DIV_SLOW(16)) dut (
    .CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .EXT_CLK_I(ext_clk), .EXT_RST_I(ext_rst), .IRQ_O(irq));
  tmr8_pins pins (.clk_i(clk), .ext_clk_o(ext_clk), .ext_rst_o(ext_rst));

  task results;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // A range is accepted because the prescalers run free from reset.
  task chk(input string nm, input int lo, input int hi,
           input logic [31:0] got);
    cmp_count++;
    if ((got >= 32'(lo) && got <= 32'(hi)) !== 1'b1) begin
      miscompares++;
      $display("mismatch %s expected %0h..%0h seen %0h", nm, lo, hi, got);
    end
  endtask

  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("mismatch pready expected 1 seen %b", pready);
      results;
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task rd(input string nm, input logic [15:0] idx, input int lo,
          input int hi);
    apb(1'b0, idx, 8'h0);
    chk(nm, lo, hi, rv);
  endtask

  task irq_is(input logic e);
    @(negedge clk);
    chk("irq", int'(e), int'(e), {31'h0, irq});
  endtask

  task t_reset;
    int e;
    for (int i = 0; i < 10; i++) begin
      e = (i > 3 && i < 7) ? 32'hff : 32'h0;
      rd("reset value", RIX[i], e, e);
    end
    irq_is(1'b0);
    apb(1'b0, 16'hffc0, 8'h0);
    chk("unmapped err", 1, 1, {31'h0, er});
    chk("unmapped data", 0, 0, rv);
  endtask

  task t_presc;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CTRL0, 8'(c));
      wr(IDX_CNT0, 8'h0);
      repeat (160) @(posedge clk);
      rd("prescaled", IDX_CNT0, EXP[c] - int'(c != 0),
         EXP[c] + int'(c != 0));
    end
    wr(IDX_CTRL0, CTRL_RST);
  endtask

  task t_ext;
    int e;
    for (int m = 5; m < 8; m++) begin
      wr(IDX_CTRL0, 8'(m));
      wr(IDX_CNT0, 8'h0);
      pins.pulse(1'b0, 0, 3);
      e = (m == 7) ? 6 : 3;
      rd("edge count", IDX_CNT0, e, e);
    end
    wr(IDX_CTRL0, CTRL_RST);
  endtask

  task t_match_b;
    wr(IDX_TCB0, 8'h2);
    wr(IDX_CTRL0, {3'h0, CCLR_NONE, CKS_EXT_RISE});
    wr(IDX_CNT0, 8'h0);
    pins.pulse(1'b0, 0, 2);
    rd("match b flag", IDX_CSR0, 8'h80, 8'h80);
    rd("irq status", IDX_IRQ_ST, 8'h04, 8'h04);
    wr(IDX_IRQ_MASK, 8'h04);
    irq_is(1'b0);
    wr(IDX_CTRL0, 8'h85);
    irq_is(1'b1);
    wr(IDX_CSR0, 8'hff);
    rd("flag after one", IDX_CSR0, 8'h80, 8'h80);
    wr(IDX_CSR0, 8'h00);
    rd("flag after zero", IDX_CSR0, 0, 0);
    wr(IDX_IRQ_ST, 8'h04);
    irq_is(1'b0);
    wr(IDX_CNT0, 8'h0);
    pins.pulse(1'b0, 0, 2);
    irq_is(1'b1);
    rd("irq status again", IDX_IRQ_ST, 8'h04, 8'h04);
    wr(IDX_IRQ_ST, 8'h04);
    wr(IDX_CTRL0, CTRL_RST);
  endtask

  task t_clear;
    wr(IDX_TCA0, 8'h3);
    wr(IDX_CNT1, 8'h0);
    wr(IDX_CTRL1, {3'h0, CCLR_NONE, CKS_CASCADE});
    wr(IDX_CNT0, 8'h0);
    wr(IDX_CTRL0, {3'h0, CCLR_MATCH_A, CKS_DIV8});
    repeat (256) @(posedge clk);
    rd("clear on a", IDX_CNT0, 0, 3);
    wr(IDX_CTRL0, CTRL_RST);
    rd("cascade count", IDX_CNT1, 10, 12);
    rd("match flags", IDX_CSR0, 8'hc0, 8'hc0);
    wr(IDX_CNT0, 8'h0);
    wr(IDX_CTRL0, {3'h0, CCLR_MATCH_B, CKS_DIV8});
    repeat (100) @(posedge clk);
    rd("clear on b", IDX_CNT0, 0, 2);
    wr(IDX_CTRL1, {3'h0, CCLR_EXT, CKS_EXT_RISE});
    wr(IDX_CNT1, 8'h0);
    pins.pulse(1'b0, 1, 3);
    rd("ext count", IDX_CNT1, 3, 3);
    pins.pulse(1'b1, 1, 1);
    rd("ext clear", IDX_CNT1, 0, 0);
  endtask

  task t_ovf;
    wr(IDX_CTRL0, {3'h0, CCLR_NONE, CKS_CASCADE});
    wr(IDX_IRQ_ST, 8'h3f);
    wr(IDX_CSR1, 8'h00);
    wr(IDX_IRQ_MASK, 8'h08);
    wr(IDX_CNT0, 8'h0);
    wr(IDX_CNT1, 8'hfe);
    wr(IDX_CTRL1, {3'h0, CCLR_NONE, CKS_EXT_RISE});
    pins.pulse(1'b0, 1, 2);
    rd("cascade ovf", IDX_CNT0, 1, 1);
    rd("ovf flags", IDX_CSR1, 8'he0, 8'he0);
    irq_is(1'b0);
    wr(IDX_CTRL1, 8'h25);
    irq_is(1'b1);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_presc;
    t_ext;
    t_match_b;
    t_clear;
    t_ovf;
    results;
  end
endmodule // test_dual_8bit_timer_control
